// File: logic/srd_pkg.sv
package srd_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // serial access framing
  localparam int unsigned ADDR_W      = 13;
  localparam int unsigned INSTR_W     = 16;
  localparam int unsigned INSTR_RW    = 15;
  localparam logic [3:0]  INSTR_LAST  = 4'hf;
  localparam logic [3:0]  BYTE_LAST   = 4'h7;
  localparam logic [3:0]  CNT_ONE     = 4'h1;
  localparam logic [3:0]  CNT_ZERO    = 4'h0;
  localparam logic [12:0] ADR_STEP    = 13'h0001;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [12:0] ADR_CFG     = 13'h0000;
  localparam logic [12:0] ADR_RBK     = 13'h0004;
  localparam logic [12:0] ADR_VER_LO  = 13'h0005;
  localparam logic [12:0] ADR_VER_HI  = 13'h0006;
  localparam logic [12:0] ADR_RA_LO   = 13'h0010;
  localparam logic [12:0] ADR_RA_HI   = 13'h0011;
  localparam logic [12:0] ADR_RB_LO   = 13'h0012;
  localparam logic [12:0] ADR_RB_HI   = 13'h0013;

  // staged register slots
  localparam int unsigned NSTG        = 6;
  localparam int unsigned IDX_VER_LO  = 0;
  localparam int unsigned IDX_VER_HI  = 1;
  localparam int unsigned IDX_RA_LO   = 2;
  localparam int unsigned IDX_RA_HI   = 3;
  localparam int unsigned IDX_RB_LO   = 4;
  localparam int unsigned IDX_RB_HI   = 5;

  ////////////////////////////////////////////////////////////////////////////
  // field layout and reset values
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [7:0]  MASK_FULL   = 8'hff;
  localparam logic [7:0]  MASK_HI2    = 8'h03;
  localparam logic        RST_BIT     = 1'b0;
  localparam int unsigned CFG_SDO_HI  = 7;
  localparam int unsigned CFG_LSB_HI  = 6;
  localparam int unsigned CFG_SRST_HI = 5;
  localparam int unsigned CFG_SRST_LO = 2;
  localparam int unsigned CFG_LSB_LO  = 1;
  localparam int unsigned CFG_SDO_LO  = 0;
  localparam int unsigned RBK_ACTIVE  = 0;
  localparam int unsigned DIV_W       = 10;
  localparam int unsigned VER_W       = 16;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser
  localparam int unsigned NPIN        = 4;
  localparam int unsigned PIN_CS      = 0;
  localparam int unsigned PIN_SCLK    = 1;
  localparam int unsigned PIN_SDIO    = 2;
  localparam int unsigned PIN_IOUPD   = 3;
  localparam logic [3:0]  PIN_RST     = 4'h1;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_INSTR,
    ST_DATA
  } srd_state_e;
endpackage

// File: logic/srd_pins_if.sv
interface srd_pins_if;
  import srd_pkg::*;
  logic [NPIN-1:0] lvl;
  logic [NPIN-1:0] rise;
  logic [NPIN-1:0] fall;
  modport src (output lvl, output rise, output fall);
  modport snk (input lvl, input rise, input fall);
endinterface

// File: logic/srd_pin_sync.sv
module srd_pin_sync (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic [srd_pkg::NPIN-1:0] raw,
  srd_pins_if.src                    pins
);
  import srd_pkg::*;

  logic [NPIN-1:0] s1_ff, s2_ff, s3_ff, flt_ff;
  logic [NPIN-1:0] nxt_s1, nxt_s2, nxt_s3, nxt_flt;

  ////////////////////////////////////////////////////////////////////////////
  // three stages; a level counts once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_pin
      always_comb begin
        nxt_s1[g]    = raw[g];
        nxt_s2[g]    = s1_ff[g];
        nxt_s3[g]    = s2_ff[g];
        nxt_flt[g]   = (s2_ff[g] == s3_ff[g]) ? s3_ff[g] : flt_ff[g];
        pins.lvl[g]  = flt_ff[g];
        pins.rise[g] = (s2_ff[g] == s3_ff[g]) & s3_ff[g] & ~flt_ff[g];
        pins.fall[g] = (s2_ff[g] == s3_ff[g]) & ~s3_ff[g] & flt_ff[g];
      end
    end
  endgenerate

  // chip select idles high so no false frame at release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_ff  <= PIN_RST;
      s2_ff  <= PIN_RST;
      s3_ff  <= PIN_RST;
      flt_ff <= PIN_RST;
    end else begin
      s1_ff  <= nxt_s1;
      s2_ff  <= nxt_s2;
      s3_ff  <= nxt_s3;
      flt_ff <= nxt_flt;
    end
  end
endmodule

// File: logic/srd_regs.sv
module srd_regs (
  input  wire logic                        clk,
  input  wire logic                        rstn,
  input  wire logic                        cs_n,
  input  wire logic                        sclk,
  input  wire logic                        sdio_i,
  output logic                             sdio_o,
  output logic                             sdio_oe,
  output logic                             serial_output_pin_o,
  output logic                             serial_output_pin_oe,
  input  wire logic                        io_update,
  output logic [srd_pkg::DIV_W-1:0]        first_reference_input_ratio,
  output logic [srd_pkg::DIV_W-1:0]        second_reference_input_ratio,
  output logic [srd_pkg::VER_W-1:0]        customer_version
);
  import srd_pkg::*;

  srd_pins_if pins ();

  srd_pin_sync u_sync (
    .clk  (clk),
    .rstn (rstn),
    .raw  ({io_update, sdio_i, sclk, cs_n}),
    .pins (pins.src)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state
  srd_state_e             state_ff, nxt_state;
  logic [3:0]             cnt_ff, nxt_cnt;
  logic [INSTR_W-1:0]     sh_ff, nxt_sh;
  logic                   rd_ff, nxt_rd;
  logic [ADDR_W-1:0]      adr_ff, nxt_adr;
  logic [7:0]             tx_ff, nxt_tx;
  logic                   lsb_ff, nxt_lsb;
  logic                   sdoact_ff, nxt_sdoact;
  logic                   rbk_ff, nxt_rbk;
  logic [7:0]             stg_ff [NSTG];
  logic [7:0]             nxt_stg [NSTG];
  logic [7:0]             act_ff [NSTG];
  logic [7:0]             nxt_act [NSTG];
  logic                   sdio_o_ff, nxt_sdio_o, sdio_oe_ff, nxt_sdio_oe;
  logic                   sdo_o_ff, nxt_sdo_o, sdo_oe_ff, nxt_sdo_oe;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [INSTR_W-1:0] rev16(input logic [INSTR_W-1:0] v);
    logic [INSTR_W-1:0] r;
    r = '0;
    for (int i = 0; i < INSTR_W; i++) begin
      r[i] = v[INSTR_W-1-i];
    end
    return r;
  endfunction

  // staged slot of an address; ratio hi bytes keep only two bits, version hi keeps all eight
  function automatic logic slot_of(input logic [ADDR_W-1:0] a, output int unsigned idx,
                                   output logic [7:0] msk);
    logic hit;
    hit = 1'b1;
    idx = IDX_VER_LO;
    msk = MASK_FULL;
    case (a)
      ADR_VER_LO: idx = IDX_VER_LO;
      ADR_VER_HI: idx = IDX_VER_HI;
      ADR_RA_LO:  idx = IDX_RA_LO;
      ADR_RA_HI: begin
        idx = IDX_RA_HI;
        msk = MASK_HI2;
      end
      ADR_RB_LO:  idx = IDX_RB_LO;
      ADR_RB_HI: begin
        idx = IDX_RB_HI;
        msk = MASK_HI2;
      end
      default:    hit = 1'b0;
    endcase
    return hit;
  endfunction

  function automatic logic [7:0] rd_val(input logic [ADDR_W-1:0] a);
    int unsigned i;
    logic [7:0]  m;
    logic [7:0]  v;
    v = RST_BYTE;
    if (a == ADR_CFG) begin
      v[CFG_SDO_HI] = sdoact_ff;
      v[CFG_SDO_LO] = sdoact_ff;
      v[CFG_LSB_HI] = lsb_ff;
      v[CFG_LSB_LO] = lsb_ff;
    end else if (a == ADR_RBK) begin
      v[RBK_ACTIVE] = rbk_ff;
    end else if (slot_of(a, i, m)) begin
      v = (rbk_ff ? act_ff[i] : stg_ff[i]) & m;
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    int unsigned wi;
    logic [7:0]  wm;
    logic [7:0]  wb;
    logic [ADDR_W-1:0] na;
    wi          = IDX_VER_LO;
    wm          = MASK_FULL;
    wb          = RST_BYTE;
    na          = adr_ff;
    nxt_state   = state_ff;
    nxt_cnt     = cnt_ff;
    nxt_sh      = sh_ff;
    nxt_rd      = rd_ff;
    nxt_adr     = adr_ff;
    nxt_tx      = tx_ff;
    nxt_lsb     = lsb_ff;
    nxt_sdoact  = sdoact_ff;
    nxt_rbk     = rbk_ff;
    nxt_stg     = stg_ff;
    nxt_act     = act_ff;
    nxt_sdio_o  = sdio_o_ff;
    nxt_sdio_oe = sdio_oe_ff;
    nxt_sdo_o   = sdo_o_ff;
    nxt_sdo_oe  = sdo_oe_ff;

    // staged values become active on an update edge
    if (pins.rise[PIN_IOUPD]) begin
      nxt_act = stg_ff;
    end

    if (pins.lvl[PIN_CS]) begin
      nxt_state   = ST_IDLE;
      nxt_cnt     = CNT_ZERO;
      nxt_sdio_oe = 1'b0;
      nxt_sdo_oe  = 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          nxt_state = ST_INSTR;
          nxt_cnt   = CNT_ZERO;
        end
        ST_INSTR: begin
          if (pins.rise[PIN_SCLK]) begin
            nxt_sh  = {sh_ff[INSTR_W-2:0], pins.lvl[PIN_SDIO]};
            nxt_cnt = cnt_ff + CNT_ONE;
            if (cnt_ff == INSTR_LAST) begin
              // bit order also governs the instruction
              if (lsb_ff) begin
                nxt_sh = rev16(nxt_sh);
              end
              nxt_rd    = nxt_sh[INSTR_RW];
              nxt_adr   = nxt_sh[ADDR_W-1:0];
              nxt_tx    = rd_val(nxt_sh[ADDR_W-1:0]);
              nxt_state = ST_DATA;
              nxt_cnt   = CNT_ZERO;
            end
          end
        end
        ST_DATA: begin
          if (pins.fall[PIN_SCLK] && rd_ff) begin
            // output pin choice and bit order
            if (sdoact_ff) begin
              nxt_sdo_o  = lsb_ff ? tx_ff[cnt_ff[2:0]] : tx_ff[BYTE_LAST[2:0] - cnt_ff[2:0]];
              nxt_sdo_oe = 1'b1;
            end else begin
              nxt_sdio_o  = lsb_ff ? tx_ff[cnt_ff[2:0]] : tx_ff[BYTE_LAST[2:0] - cnt_ff[2:0]];
              nxt_sdio_oe = 1'b1;
            end
          end
          if (pins.rise[PIN_SCLK]) begin
            nxt_sh  = lsb_ff ? {sh_ff[INSTR_W-1:8], pins.lvl[PIN_SDIO], sh_ff[7:1]}
                             : {sh_ff[INSTR_W-1:8], sh_ff[6:0], pins.lvl[PIN_SDIO]};
            nxt_cnt = cnt_ff + CNT_ONE;
            if (cnt_ff == BYTE_LAST) begin
              wb      = nxt_sh[7:0];
              nxt_cnt = CNT_ZERO;
              // lsb-first streams upward, msb-first downward
              na      = lsb_ff ? ADDR_W'(adr_ff + ADR_STEP) : ADDR_W'(adr_ff - ADR_STEP);
              nxt_adr = na;
              if (rd_ff) begin
                nxt_tx = rd_val(na);
              end else if (adr_ff == ADR_CFG) begin
                // either soft reset copy clears the whole map
                if (wb[CFG_SRST_HI] | wb[CFG_SRST_LO]) begin
                  nxt_lsb    = RST_BIT;
                  nxt_sdoact = RST_BIT;
                  nxt_rbk    = RST_BIT;
                  for (int k = 0; k < NSTG; k++) begin
                    nxt_stg[k] = RST_BYTE;
                    nxt_act[k] = RST_BYTE;
                  end
                end else begin
                  nxt_lsb    = wb[CFG_LSB_HI] | wb[CFG_LSB_LO];
                  nxt_sdoact = wb[CFG_SDO_HI] | wb[CFG_SDO_LO];
                end
              end else if (adr_ff == ADR_RBK) begin
                nxt_rbk = wb[RBK_ACTIVE];
              end else if (slot_of(adr_ff, wi, wm)) begin
                // staged byte, reserved bits kept zero
                nxt_stg[wi] = wb & wm;
              end
              // any other address falls through untouched
            end
          end
        end
        default: begin
          nxt_state = ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff   <= ST_IDLE;
      cnt_ff     <= CNT_ZERO;
      sh_ff      <= '0;
      rd_ff      <= RST_BIT;
      adr_ff     <= ADR_CFG;
      tx_ff      <= RST_BYTE;
      lsb_ff     <= RST_BIT;
      sdoact_ff  <= RST_BIT;
      rbk_ff     <= RST_BIT;
      sdio_o_ff  <= RST_BIT;
      sdio_oe_ff <= RST_BIT;
      sdo_o_ff   <= RST_BIT;
      sdo_oe_ff  <= RST_BIT;
      for (int k = 0; k < NSTG; k++) begin
        stg_ff[k] <= RST_BYTE;
        act_ff[k] <= RST_BYTE;
      end
    end else begin
      state_ff   <= nxt_state;
      cnt_ff     <= nxt_cnt;
      sh_ff      <= nxt_sh;
      rd_ff      <= nxt_rd;
      adr_ff     <= nxt_adr;
      tx_ff      <= nxt_tx;
      lsb_ff     <= nxt_lsb;
      sdoact_ff  <= nxt_sdoact;
      rbk_ff     <= nxt_rbk;
      sdio_o_ff  <= nxt_sdio_o;
      sdio_oe_ff <= nxt_sdio_oe;
      sdo_o_ff   <= nxt_sdo_o;
      sdo_oe_ff  <= nxt_sdo_oe;
      stg_ff     <= nxt_stg;
      act_ff     <= nxt_act;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from flops
  assign sdio_o                       = sdio_o_ff;
  assign sdio_oe                      = sdio_oe_ff;
  assign serial_output_pin_o          = sdo_o_ff;
  assign serial_output_pin_oe         = sdo_oe_ff;
  assign first_reference_input_ratio  = {act_ff[IDX_RA_HI][1:0], act_ff[IDX_RA_LO]};
  assign second_reference_input_ratio = {act_ff[IDX_RB_HI][1:0], act_ff[IDX_RB_LO]};
  assign customer_version             = {act_ff[IDX_VER_HI], act_ff[IDX_VER_LO]};
endmodule

// File: bench/srd_asserts.sv
module srd_chk (
  input wire logic                       clk,
  input wire logic                       rstn,
  input wire logic                       cs_n,
  input wire logic                       io_update,
  input wire logic                       sdio_oe,
  input wire logic                       serial_output_pin_oe,
  input wire logic [srd_pkg::DIV_W-1:0]  first_reference_input_ratio,
  input wire logic [srd_pkg::DIV_W-1:0]  second_reference_input_ratio,
  input wire logic [srd_pkg::VER_W-1:0]  customer_version
);
  timeunit 1ns;
  timeprecision 1ns;
  import srd_pkg::*;
  logic       upd_q_ff;
  logic [3:0] upd_age_ff;
  logic [3:0] nxt_upd_age;
  logic [3:0] cs_hi_ff;
  logic [3:0] nxt_cs_hi;
  ////////////////////////////////////////////////////////////////////////////
  // saturating ages: raw pin edges, so the bounds carry the sync latency
  always_comb begin
    nxt_upd_age = upd_age_ff + ((upd_age_ff != 4'hf) ? 4'h1 : 4'h0);
    if (io_update && !upd_q_ff) nxt_upd_age = 4'h0;
    nxt_cs_hi = cs_n ? cs_hi_ff + ((cs_hi_ff != 4'hf) ? 4'h1 : 4'h0) : 4'h0;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      upd_q_ff   <= 1'b0;
      upd_age_ff <= 4'hf;
      cs_hi_ff   <= 4'hf;
    end else begin
      upd_q_ff   <= io_update;
      upd_age_ff <= nxt_upd_age;
      cs_hi_ff   <= nxt_cs_hi;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_cs_idle;
    cs_n [*8];
  endsequence
  sequence s_fresh_upd;
    upd_age_ff <= 4'h8;
  endsequence
  a_reset_zero: assert property ($rose(rstn) |-> first_reference_input_ratio == '0
    && second_reference_input_ratio == '0 && customer_version == '0)
    else $error("active words not zero after reset");
  a_ratio_a_upd: assert property ($changed(first_reference_input_ratio)
    && first_reference_input_ratio != '0 |-> s_fresh_upd)
    else $error("first ratio changed without update");
  a_ratio_b_upd: assert property ($changed(second_reference_input_ratio)
    && second_reference_input_ratio != '0 |-> s_fresh_upd)
    else $error("second ratio changed without update");
  a_version_upd: assert property ($changed(customer_version)
    && customer_version != '0 |-> s_fresh_upd)
    else $error("version changed without update");
  a_oe_one_pin: assert property (!(sdio_oe && serial_output_pin_oe))
    else $error("both read pins driven");
  a_oe_idle: assert property (s_cs_idle |-> !sdio_oe && !serial_output_pin_oe)
    else $error("read pin driven while deselected");
  a_oe_rise_sel: assert property ($rose(sdio_oe) || $rose(serial_output_pin_oe) |-> !cs_n)
    else $error("drive began while deselected");
  a_oe_fall_late: assert property ($fell(sdio_oe) |-> cs_hi_ff >= 4'h1 && cs_hi_ff <= 4'h9)
    else $error("sdio released out of time");
endmodule
bind srd_regs srd_chk u_chk (.clk(clk), .rstn(rstn), .cs_n(cs_n), .io_update(io_update),
  .sdio_oe(sdio_oe), .serial_output_pin_oe(serial_output_pin_oe),
  .first_reference_input_ratio(first_reference_input_ratio),
  .second_reference_input_ratio(second_reference_input_ratio),
  .customer_version(customer_version));

// File: bench/srd_host.sv
module srd_host (
  input  wire logic  clk,
  input  wire logic  sdio_o,
  input  wire logic  serial_output_pin_o,
  output logic       cs_n,
  output logic       sclk,
  output logic       sdio_i
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int H = 8;
  logic drv  = 1'b1;
  logic four = 1'b0;
  logic lsb  = 1'b0;
  initial begin
    cs_n   = 1'b1;
    sclk   = 1'b0;
    sdio_i = 1'b0;
  end
  // released line toggles so a stale bit never reads as data
  always @(posedge clk) if (!drv) sdio_i <= ~sdio_i;
  task automatic shift(input logic [31:0] v, input int nb, output logic [31:0] r);
    int i;
    r = '0;
    for (int j = 0; j < nb; j++) begin
      // lsb-first sends bit 0 first
      i = lsb ? j : nb - 1 - j;
      @(posedge clk);
      if (drv) sdio_i <= v[i];
      repeat (H) @(posedge clk);
      sclk <= 1'b1;
      r[i] = four ? serial_output_pin_o : sdio_o;
      repeat (H) @(posedge clk);
      sclk <= 1'b0;
    end
  endtask
  // instruction then n data bytes; msb-first walks down, lsb-first up
  task automatic frame(input logic rd, input logic [12:0] adr, input int n,
                       input logic [15:0] wd, output logic [15:0] rv);
    logic [31:0] r;
    @(posedge clk);
    cs_n <= 1'b0;
    drv = 1'b1;
    repeat (H) @(posedge clk);
    shift({16'h0000, rd, 2'b00, adr}, 16, r);
    if (rd) drv = 1'b0;
    shift({16'h0000, wd}, n * 8, r);
    rv = r[15:0];
    repeat (H) @(posedge clk);
    cs_n <= 1'b1;
    drv = 1'b1;
    repeat (2 * H) @(posedge clk);
  endtask
endmodule

// File: bench/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import srd_pkg::*;
  logic             clk = 1'b0;
  logic             rstn = 1'b0;
  logic             io_update = 1'b0;
  logic             cs_n, sclk, sdio_i, sdio_o, sdio_oe, sdo_o, sdo_oe;
  logic [DIV_W-1:0] ra, rb;
  logic [VER_W-1:0] ver;
  int               mismatches = 0;
  int               n_tests = 0;
  int               cyc = 0;
  logic [12:0]      adrs [8] = '{ADR_CFG, ADR_RBK, ADR_VER_LO, ADR_VER_HI,
                                 ADR_RA_LO, ADR_RA_HI, ADR_RB_LO, ADR_RB_HI};
  always #20 clk = ~clk;
  // undriven read lines float to their pull-up level
  srd_host host (.clk(clk), .sdio_o(sdio_oe ? sdio_o : 1'b1),
                 .serial_output_pin_o(sdo_oe ? sdo_o : 1'b1),
                 .cs_n(cs_n), .sclk(sclk), .sdio_i(sdio_i));
  srd_regs dut (.clk(clk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk), .sdio_i(sdio_i),
                .sdio_o(sdio_o), .sdio_oe(sdio_oe), .serial_output_pin_o(sdo_o),
                .serial_output_pin_oe(sdo_oe), .io_update(io_update),
                .first_reference_input_ratio(ra), .second_reference_input_ratio(rb),
                .customer_version(ver));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [12:0] a, input int n, input logic [15:0] d);
    logic [15:0] r;
    host.frame(1'b0, a, n, d, r);
  endtask
  task automatic rd_chk(input logic [12:0] a, input logic [7:0] e);
    logic [15:0] r;
    host.frame(1'b1, a, 1, 16'h0000, r);
    chk(r, {8'h00, e});
  endtask
  task automatic pulse_upd();
    io_update <= 1'b1;
    repeat (8) @(posedge clk);
    io_update <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_all_zero();
    foreach (adrs[i]) rd_chk(adrs[i], 8'h00);
    chk({ra, rb}, 32'h0000_0000);
    chk(ver, 32'h0000_0000);
  endtask
  task automatic t_stage();
    wr(ADR_RA_HI, 2, 16'h035a);
    wr(ADR_RB_HI, 2, 16'h02c3);
    wr(ADR_VER_HI, 2, 16'hbeef);
    chk({ra, rb}, 32'h0000_0000);
    pulse_upd();
    chk(ra, 32'h0000_035a);
    chk(rb, 32'h0000_02c3);
    chk(ver, 32'h0000_beef);
    rd_chk(ADR_RA_HI, 8'h03);
  endtask
  task automatic t_readback();
    wr(ADR_VER_LO, 1, 16'h0011);
    rd_chk(ADR_VER_LO, 8'h11);
    wr(ADR_RBK, 1, 16'h0001);
    rd_chk(ADR_RBK, 8'h01);
    rd_chk(ADR_VER_LO, 8'hef);
    wr(ADR_RBK, 1, 16'h0000);
  endtask
  task automatic t_unmapped();
    wr(13'h0007, 1, 16'h00ff);
    wr(13'h0020, 1, 16'h00ff);
    rd_chk(13'h0007, 8'h00);
    rd_chk(ADR_RA_LO, 8'h5a);
    pulse_upd();
    chk(ver, 32'h0000_be11);
    chk(ra, 32'h0000_035a);
  endtask
  task automatic t_out_pin();
    wr(ADR_CFG, 1, 16'h0081);
    host.four = 1'b1;
    rd_chk(ADR_RB_LO, 8'hc3);
    rd_chk(ADR_CFG, 8'h81);
  endtask
  task automatic t_lsb();
    wr(ADR_CFG, 1, 16'h0042);
    host.four = 1'b0;
    host.lsb = 1'b1;
    // lsb-first streams upward from the low byte
    wr(ADR_RB_LO, 2, 16'h0155);
    rd_chk(ADR_RB_HI, 8'h01);
    rd_chk(ADR_RB_LO, 8'h55);
    rd_chk(ADR_CFG, 8'h42);
    pulse_upd();
    chk(rb, 32'h0000_0155);
  endtask
  task automatic t_soft_reset();
    // soft reset sent lsb-first must also drop bit order
    wr(ADR_CFG, 1, 16'h0024);
    host.lsb = 1'b0;
    t_all_zero();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // ceiling sits well above the expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    t_all_zero();
    t_stage();
    t_readback();
    t_unmapped();
    t_out_pin();
    t_lsb();
    t_soft_reset();
    end_sim();
  end
endmodule
